/* File: logic/srs_reset_sequencer.sv */
// System reset sequencer: holds the core, forces defaults, reloads the device key
`timescale 1ns/1ns
`include "srs_defines.svh"

module srs_reset_sequencer (
   input  wire logic                  core_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  vmon_rst_i,
   input  wire logic                  rst_pin_i,
   input  wire logic                  wdt_rst_i,
   input  wire logic                  sw_rst_i,
   input  wire logic [127:0]          unique_device_key_i,
   input  wire logic                  fw_we_i,
   input  wire logic [3:0]            fw_waddr_i,
   input  wire logic [7:0]            fw_wdata_i,
   input  wire logic [3:0]            fw_raddr_i,
   output logic      [7:0]            fw_rdata_o,
   output srs_pkg::srs_core_ctl_s     core_ctl_o,
   output logic                       core_start_o,
   output logic      [15:0]           fetch_addr_o,
   output logic                       periph_rst_o,
   output logic                       por_only_rst_o,
   output srs_pkg::srs_port_ctl_s     port_ctl_o,
   output logic                       irq_disable_o,
   output logic                       timer_disable_o,
   output logic                       rst_pin_o,
   output logic                       rst_pin_oe_o,
   output logic                       key_load_busy_o,
   output srs_pkg::srs_cause_s        last_cause_o
);

   // ==========================================
   // Functions
   function automatic logic [7:0] key_byte(input logic [127:0] key, input logic [3:0] idx);
      key_byte = key[{idx, 3'b000} +: 8];
   endfunction

   // ==========================================
   // Source synchronisation
   // Pins are asynchronous; the spare lane delays our own pin drive so it cannot re-trigger
   logic       pin_oe_reg;
   logic [2:0] async_src;
   logic [2:0] sync_src;
   logic       vmon_sync;
   logic       pin_sync;
   logic       any_src;

   assign async_src = {vmon_rst_i, rst_pin_i, pin_oe_reg};

   srs_sync u_sync (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .async_i    (async_src),
      .sync_o     (sync_src)
   );

   assign vmon_sync = sync_src[2];
   assign pin_sync  = ~sync_src[1] & ~pin_oe_reg & ~sync_src[0];
   assign any_src   = vmon_sync | pin_sync | wdt_rst_i | sw_rst_i;

   // ==========================================
   // Sequencer state
   srs_pkg::srs_state_e state_reg;
   srs_pkg::srs_state_e state_next;
   logic [3:0]          idx_reg;
   logic [3:0]          idx_next;
   logic                in_reset_next;
   logic                enter_run;

   always_comb begin
      state_next = state_reg;
      idx_next   = idx_reg;
      case (state_reg)
         srs_pkg::ST_HOLD: begin
            if (!any_src) begin
               state_next = srs_pkg::ST_LOAD;
               idx_next   = `SRS_KEY_FIRST_IDX;
            end
         end
         srs_pkg::ST_LOAD: begin
            if (any_src) begin
               state_next = srs_pkg::ST_HOLD;
            end else if (idx_reg == `SRS_KEY_LAST_IDX) begin
               state_next = srs_pkg::ST_RUN;
            end else begin
               idx_next = idx_reg + 4'h1;
            end
         end
         srs_pkg::ST_RUN: begin
            if (any_src) begin
               state_next = srs_pkg::ST_HOLD;
            end
         end
         default: begin
            state_next = srs_pkg::ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= srs_pkg::ST_HOLD;
         idx_reg   <= `SRS_KEY_FIRST_IDX;
      end else begin
         state_reg <= state_next;
         idx_reg   <= idx_next;
      end
   end

   // Key reload counts as part of the reset state, so the core stays halted
   assign in_reset_next = (state_next != srs_pkg::ST_RUN);
   assign enter_run     = (state_next == srs_pkg::ST_RUN) && (state_reg != srs_pkg::ST_RUN);

   // ==========================================
   // Reset causes
   // Power-on is marked by the async reset itself; set wins over clear
   srs_pkg::srs_cause_s cur_cause;
   srs_pkg::srs_cause_s acc_reg;
   srs_pkg::srs_cause_s acc_next;
   srs_pkg::srs_cause_s last_reg;
   srs_pkg::srs_cause_s last_next;

   always_comb begin
      cur_cause      = '0;
      cur_cause.vmon = vmon_sync;
      cur_cause.pin  = pin_sync;
      cur_cause.wdt  = wdt_rst_i;
      cur_cause.sw   = sw_rst_i;
      last_next      = last_reg;
      if (state_reg == srs_pkg::ST_RUN) begin
         acc_next = cur_cause;
      end else begin
         acc_next = acc_reg | cur_cause;
      end
      if (enter_run) begin
         last_next = acc_reg;
         acc_next  = cur_cause;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         acc_reg     <= '0;
         acc_reg.por <= 1'b1;
         last_reg    <= '0;
      end else begin
         acc_reg  <= acc_next;
         last_reg <= last_next;
      end
   end

   // ==========================================
   // Output controls
   srs_pkg::srs_core_ctl_s core_reg;
   srs_pkg::srs_core_ctl_s core_next;
   srs_pkg::srs_port_ctl_s port_reg;
   srs_pkg::srs_port_ctl_s port_next;
   logic                   start_reg;
   logic                   start_next;
   logic [15:0]            fetch_reg;
   logic                   periph_reg;
   logic                   periph_next;
   logic                   por_rst_reg;
   logic                   por_rst_next;
   logic                   gate_reg;
   logic                   gate_next;
   logic                   pin_oe_next;
   logic                   busy_reg;
   logic                   busy_next;

   always_comb begin
      core_next.halt     = in_reset_next;
      // Clear PC and pick low-power oscillator through reset
      core_next.pc_clear = in_reset_next;
      core_next.clk_lpo  = in_reset_next | core_reg.clk_lpo;
      // Watchdog comes up enabled on exit
      core_next.wdt_en   = ~in_reset_next;
      start_next         = enter_run;
      // Defaults; power-on-only bits reset only for a power-on cause
      periph_next        = in_reset_next;
      por_rst_next       = in_reset_next & acc_next.por;
      // Ports forced; latches one, open drain
      port_next.latch_one  = in_reset_next ? `SRS_PORT_LATCH_RST : port_reg.latch_one;
      port_next.open_drain = in_reset_next ? `SRS_PORT_OD_RST : port_reg.open_drain;
      port_next.pullup_en  = `SRS_PULLUP_RST;
      gate_next          = in_reset_next;
      // Drive pin low for a supply monitor reset
      pin_oe_next        = in_reset_next & acc_next.vmon;
      busy_next          = (state_next == srs_pkg::ST_LOAD);
   end

   // Clock select and port fields hold after release; software owners move them later
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         core_reg             <= '0;
         core_reg.halt        <= 1'b1;
         core_reg.pc_clear    <= 1'b1;
         core_reg.clk_lpo     <= 1'b1;
         start_reg            <= 1'b0;
         fetch_reg            <= `SRS_START_ADDR;
         periph_reg           <= 1'b1;
         por_rst_reg          <= 1'b1;
         port_reg.latch_one   <= `SRS_PORT_LATCH_RST;
         port_reg.open_drain  <= `SRS_PORT_OD_RST;
         port_reg.pullup_en   <= `SRS_PULLUP_RST;
         gate_reg             <= 1'b1;
         pin_oe_reg           <= 1'b0;
         busy_reg             <= 1'b0;
      end else begin
         core_reg    <= core_next;
         start_reg   <= start_next;
         fetch_reg   <= `SRS_START_ADDR;
         periph_reg  <= periph_next;
         por_rst_reg <= por_rst_next;
         port_reg    <= port_next;
         gate_reg    <= gate_next;
         pin_oe_reg  <= pin_oe_next;
         busy_reg    <= busy_next;
      end
   end

   assign core_ctl_o      = core_reg;
   assign core_start_o    = start_reg;
   assign fetch_addr_o    = fetch_reg;
   assign periph_rst_o    = periph_reg;
   assign por_only_rst_o  = por_rst_reg;
   assign port_ctl_o      = port_reg;
   assign irq_disable_o   = gate_reg;
   assign timer_disable_o = gate_reg;
   assign rst_pin_o       = `SRS_PIN_DRIVE_LVL;
   assign rst_pin_oe_o    = pin_oe_reg;
   assign key_load_busy_o = busy_reg;
   assign last_cause_o    = last_reg;

   // ==========================================
   // Key RAM port
   logic       ram_we;
   logic [3:0] ram_waddr;
   logic [7:0] ram_wdata;

   always_comb begin
      ram_we    = 1'b0;
      ram_waddr = fw_waddr_i;
      ram_wdata = fw_wdata_i;
      if (state_reg == srs_pkg::ST_LOAD) begin
         // Loader owns the port during reload
         ram_we    = 1'b1;
         ram_waddr = idx_reg;
         ram_wdata = key_byte(unique_device_key_i, idx_reg);
      end else if (state_reg == srs_pkg::ST_RUN) begin
         // No write protection in normal operation
         ram_we    = fw_we_i;
      end
   end

   srs_key_ram u_key_ram (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .we_i       (ram_we),
      .waddr_i    (ram_waddr),
      .wdata_i    (ram_wdata),
      .raddr_i    (fw_raddr_i),
      .rdata_o    (fw_rdata_o)
   );

   // ==========================================
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_halt_on_source: assert property (any_src |=> core_ctl_o.halt && !core_start_o)
      else $error("core not halted after reset source");
   a_por_bits_kept: assert property (
      (state_reg == srs_pkg::ST_RUN) && wdt_rst_i |=> periph_rst_o && !por_only_rst_o)
      else $error("power-on-only reset on watchdog reset");
   a_port_forced: assert property (
      core_ctl_o.halt |-> port_ctl_o.latch_one && port_ctl_o.open_drain)
      else $error("port not forced during reset");
   a_gates_closed: assert property (
      core_ctl_o.halt |-> irq_disable_o && timer_disable_o)
      else $error("interrupts or timers live in reset");
   a_ram_untouched: assert property ((state_reg == srs_pkg::ST_HOLD) |-> !ram_we)
      else $error("RAM written while holding reset");
   a_latch_one: assert property ($fell(core_ctl_o.halt) |-> port_ctl_o.latch_one)
      else $error("port latch not one at release");
   a_pullup_kept: assert property (port_ctl_o.pullup_en)
      else $error("pull-ups disabled");
   a_pin_driven: assert property (
      vmon_sync |=> rst_pin_oe_o && (rst_pin_o == 1'b0) ##0 rst_pin_oe_o [*1])
      else $error("reset pin not driven for supply reset");
   a_pin_freed: assert property ($fell(core_ctl_o.halt) |-> !rst_pin_oe_o)
      else $error("reset pin still driven after exit");
   a_exit_state: assert property (
      $fell(core_ctl_o.halt) |-> core_ctl_o.wdt_en && core_ctl_o.clk_lpo
                                && $past(core_ctl_o.pc_clear))
      else $error("exit defaults wrong");
   a_start_zero: assert property (
      core_start_o |-> fetch_addr_o == `SRS_START_ADDR && $fell(core_ctl_o.halt))
      else $error("start not at address zero");
   a_key_bytes: assert property (
      state_reg == srs_pkg::ST_LOAD |-> ram_we && ram_waddr == idx_reg
         && ram_wdata == key_byte(unique_device_key_i, idx_reg))
      else $error("key byte written wrong");
   a_load_length: assert property (
      (state_reg == srs_pkg::ST_LOAD) && (state_next == srs_pkg::ST_RUN)
         |-> idx_reg == `SRS_KEY_LAST_IDX ##1 core_start_o)
      else $error("key load length wrong");
   a_fw_write: assert property (
      (state_reg == srs_pkg::ST_RUN) && fw_we_i |-> ram_we && ram_waddr == fw_waddr_i)
      else $error("firmware write blocked");
   a_sync_release: assert property (
      (state_reg == srs_pkg::ST_HOLD) && !any_src |=> state_reg == srs_pkg::ST_LOAD)
      else $error("release not taken");

   c_vmon_reset: cover property (vmon_sync ##1 rst_pin_oe_o);
   c_full_load: cover property (key_load_busy_o ##1 core_start_o);
   c_load_abort: cover property ((state_reg == srs_pkg::ST_LOAD) && any_src);
   c_fw_key_write: cover property ((state_reg == srs_pkg::ST_RUN) && fw_we_i);

endmodule

/* File: logic/srs_defines.svh */
// Constants of the system reset sequencer
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// Program start address after release
`define SRS_START_ADDR     16'h0000
// Identifier geometry, top 16 bytes of the data RAM
`define SRS_KEY_LAST_IDX   4'hF
`define SRS_KEY_FIRST_IDX  4'h0
// Port defaults while in reset
`define SRS_PORT_LATCH_RST 1'b1
`define SRS_PORT_OD_RST    1'b1
`define SRS_PULLUP_RST     1'b1
// Synchroniser reset levels: {vmon, pin_n, own pin drive}
`define SRS_SYNC_RST       3'b101
// Reset pin drive level (active low pin)
`define SRS_PIN_DRIVE_LVL  1'b0

`endif

/* File: logic/srs_pkg.sv */
// Types shared by the system reset sequencer files
package srs_pkg;

   typedef enum logic [1:0] {
      ST_HOLD = 2'b00,
      ST_LOAD = 2'b01,
      ST_RUN  = 2'b10
   } srs_state_e;

   typedef struct packed {
      logic por;
      logic vmon;
      logic pin;
      logic wdt;
      logic sw;
   } srs_cause_s;

   typedef struct packed {
      logic latch_one;
      logic open_drain;
      logic pullup_en;
   } srs_port_ctl_s;

   typedef struct packed {
      logic halt;
      logic pc_clear;
      logic clk_lpo;
      logic wdt_en;
   } srs_core_ctl_s;

endpackage

/* File: logic/srs_sync.sv */
// Two-flop synchroniser for asynchronous reset sources
`timescale 1ns/1ns
`include "srs_defines.svh"

module srs_sync (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [2:0] async_i,
   output logic      [2:0] sync_o
);

   logic [2:0] meta_reg;
   logic [2:0] sync_reg;

   // ==========================================
   // Synchroniser
   // Resets to the asserted levels so the supply monitor source looks active at power-up; the own-drive lane masks the pin
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_reg <= `SRS_SYNC_RST;
         sync_reg <= `SRS_SYNC_RST;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule

/* File: logic/srs_key_ram.sv */
// Top sixteen bytes of the data RAM holding the device key
`timescale 1ns/1ns

module srs_key_ram (
   input  wire logic       core_clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       we_i,
   input  wire logic [3:0] waddr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [3:0] raddr_i,
   output logic      [7:0] rdata_o
);

   logic [7:0] mem [0:15];
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // ==========================================
   // Storage
   // No reset on the array
   always_ff @(posedge core_clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // ==========================================
   // Registered read
   always_comb begin
      rdata_next = mem[raddr_i];
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;

endmodule

/* File: testbench/test_system_reset_sequencer.sv */
// Self-checking testbench of the system reset sequencer
`timescale 1ns/1ns

module test_system_reset_sequencer;

   // ==========================================
   // Signals
   logic                   clk;
   logic                   sys_rst;
   logic                   vmon;
   logic                   pin_drv;
   logic                   pin_w;
   logic                   wdt;
   logic                   sw;
   logic [127:0]           key;
   logic [127:0]           wkey;
   logic                   we;
   logic [3:0]             waddr;
   logic [7:0]             wdata;
   logic [3:0]             raddr;
   logic [7:0]             rdata;
   srs_pkg::srs_core_ctl_s core_ctl;
   logic                   start;
   logic [15:0]            fetch;
   logic                   periph;
   logic                   por_only;
   srs_pkg::srs_port_ctl_s port_ctl;
   logic                   irq_dis;
   logic                   tmr_dis;
   logic                   pin_lvl;
   logic                   pin_oe;
   logic                   busy;
   srs_pkg::srs_cause_s    cause;
   int                     errors;
   int                     check_count;
   int                     seed;
   int                     n;
   int                     cbit[4] = '{1, 0, 2, 3};

   // Pin has an external pull-up; the block pulls it low when enabled
   assign pin_w = pin_oe ? pin_lvl : pin_drv;

   srs_reset_sequencer dut (
      .core_clk_i(clk), .sys_rst_i(sys_rst), .vmon_rst_i(vmon), .rst_pin_i(pin_w),
      .wdt_rst_i(wdt), .sw_rst_i(sw), .unique_device_key_i(key), .fw_we_i(we),
      .fw_waddr_i(waddr), .fw_wdata_i(wdata), .fw_raddr_i(raddr), .fw_rdata_o(rdata),
      .core_ctl_o(core_ctl), .core_start_o(start), .fetch_addr_o(fetch),
      .periph_rst_o(periph), .por_only_rst_o(por_only), .port_ctl_o(port_ctl),
      .irq_disable_o(irq_dis), .timer_disable_o(tmr_dis), .rst_pin_o(pin_lvl),
      .rst_pin_oe_o(pin_oe), .key_load_busy_o(busy), .last_cause_o(cause)
   );

   // ==========================================
   // Helpers
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic check(input logic [127:0] seen, input logic [127:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   function automatic logic [127:0] rnd_key();
      return {$random(seed), $random(seed), $random(seed), $random(seed)};
   endfunction

   // Called right after a falling edge
   task automatic drive(input int s, input logic v);
      case (s)
         0: wdt = v;
         1: sw = v;
         2: pin_drv = ~v;
         default: vmon = v;
      endcase
   endtask

   task automatic wait_start(output int cnt);
      cnt = 0;
      while (start !== 1'b1 && cnt < 80) begin
         @(negedge clk);
         cnt++;
      end
   endtask

   task automatic in_reset(input logic por);
      check(core_ctl, 4'b1110);
      check({periph, irq_dis, tmr_dis}, 3'b111);
      check(port_ctl, 3'b111);
      check(por_only, por);
   endtask

   task automatic run_ok();
      check(start, 1'b1);
      check(core_ctl, 4'b0011);
      check(fetch, 16'h0000);
      check({periph, irq_dis, tmr_dis, busy}, 4'h0);
      check(port_ctl, 3'b111);
      check(pin_oe, 1'b0);
   endtask

   task automatic chk_key(input logic [127:0] k);
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         raddr = i[3:0];
         @(negedge clk);
         check(rdata, k[8*i+:8]);
      end
   endtask

   // ==========================================
   // Watchdog: whole run is well under this span
   initial begin
      #(50 * 20000);
      errors++;
      stop_test();
   end

   // ==========================================
   // Main sequence
   initial begin
      seed = 41882;
      errors = 0;
      check_count = 0;
      sys_rst = 1'b1;
      vmon = 1'b0;
      pin_drv = 1'b1;
      wdt = 1'b0;
      sw = 1'b0;
      we = 1'b0;
      waddr = 4'h0;
      wdata = 8'h00;
      raddr = 4'h0;
      key = rnd_key();
      repeat (20) @(negedge clk);
      in_reset(1'b1);
      check(pin_oe, 1'b0);
      sys_rst = 1'b0;
      wait_start(n);
      run_ok();
      chk_key(key);

      // Back-to-back firmware writes over the key area
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         we = 1'b1;
         waddr = i[3:0];
         wdata = 8'($random(seed));
         wkey[8*i+:8] = wdata;
      end
      @(negedge clk);
      we = 1'b0;
      chk_key(wkey);

      // Every reset source in turn, fresh key each time
      for (int s = 0; s < 4; s++) begin
         key = rnd_key();
         drive(s, 1'b1);
         repeat (6) @(negedge clk);
         in_reset(1'b0);
         check(pin_oe, s == 3);
         drive(s, 1'b0);
         wait_start(n);
         if (s < 2) begin
            check(n, 17);
         end
         run_ok();
         check(cause[cbit[s]], 1'b1);
         check(cause.por, 1'b0);
         chk_key(key);
      end

      // Reset during key reload restarts it with the new key
      drive(1, 1'b1);
      @(negedge clk);
      drive(1, 1'b0);
      n = 0;
      while (busy !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      repeat (4) @(negedge clk);
      key = rnd_key();
      drive(1, 1'b1);
      @(negedge clk);
      drive(1, 1'b0);
      wait_start(n);
      check(n, 17);
      run_ok();
      chk_key(key);

      // Power-on reset in mid-run, with a write tried during reload
      key = rnd_key();
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      in_reset(1'b1);
      check(cause, 5'h00);
      sys_rst = 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      repeat (4) @(negedge clk);
      we = 1'b1;
      waddr = 4'h0;
      wdata = ~key[7:0];
      @(negedge clk);
      we = 1'b0;
      wait_start(n);
      run_ok();
      chk_key(key);
      stop_test();
   end

endmodule
